// [common/ubc_cfg.svh]
// Register offsets, field layout and reset values of the byte count block.
// Assumes the special function register space uses eight-bit addresses.
`ifndef UBC_CFG_SVH
`define UBC_CFG_SVH

// ==========================================================================
// Register offsets
`define UBC_ADDR_EP_FIFO_RESET 8'hD5
`define UBC_ADDR_RX_COUNT_LOW 8'hE2
`define UBC_ADDR_RX_COUNT_HIGH 8'hE3

// ==========================================================================
// Field layout
`define UBC_NUM_EP 7
`define UBC_COUNT_W 11
`define UBC_LOW_MSB 7
`define UBC_HIGH_LSB 8
`define UBC_HIGH_W 3
`define UBC_EP_RST_MSB 6

// ==========================================================================
// Reset values
`define UBC_EP_FIFO_RESET_INIT 7'h00
`define UBC_RDATA_INIT 8'h00

`endif

// [common/ubc_pkg.sv]
// Types shared by the byte count block.
// Assumes ubc_cfg.svh is on the include path.
`include "ubc_cfg.svh"

package ubc_pkg;

    // ======================================================================
    // Register selection
    typedef enum logic [3:0] {
        UBC_SEL_NONE = 4'h1,
        UBC_SEL_LOW = 4'h2,
        UBC_SEL_HIGH = 4'h4,
        UBC_SEL_RST = 4'h8
    } ubc_reg_sel_t;

    typedef logic [`UBC_COUNT_W-1:0] ubc_count_t;

endpackage

// [src/ubc_ep_count.sv]
// One endpoint's FIFO pointers and last received packet byte count.
// Assumes all strobes are one-cycle pulses on the system clock.
`timescale 1ns/1ps
`include "ubc_cfg.svh"

module ubc_ep_count #(
    parameter int CNT_W = `UBC_COUNT_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic fifo_clear,
    input wire logic byte_wr,
    input wire logic byte_rd,
    input wire logic pkt_done,
    output logic [CNT_W-1:0] wr_ptr_r,
    output logic [CNT_W-1:0] rd_ptr_r,
    output logic [CNT_W-1:0] count_r
);

    // ======================================================================
    // Next state
    logic [CNT_W-1:0] wr_ptr_nxt;
    logic [CNT_W-1:0] rd_ptr_nxt;
    logic [CNT_W-1:0] count_nxt;
    logic [CNT_W-1:0] pkt_len_r;
    logic [CNT_W-1:0] pkt_len_nxt;
    logic [CNT_W-1:0] pkt_sum;

    assign pkt_sum = pkt_len_r + CNT_W'(byte_wr);

    always_comb begin
        wr_ptr_nxt = wr_ptr_r;
        rd_ptr_nxt = rd_ptr_r;
        count_nxt = count_r;
        pkt_len_nxt = pkt_len_r;
        if (fifo_clear) begin
            wr_ptr_nxt = '0;
            rd_ptr_nxt = '0;
            count_nxt = '0;
            pkt_len_nxt = '0;
        end else begin
            if (byte_wr) begin
                wr_ptr_nxt = wr_ptr_r + CNT_W'(1);
            end
            if (byte_rd) begin
                rd_ptr_nxt = rd_ptr_r + CNT_W'(1);
            end
            if (pkt_done) begin
                count_nxt = pkt_sum;
                pkt_len_nxt = '0;
            end else begin
                pkt_len_nxt = pkt_sum;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
            pkt_len_r <= '0;
        end else begin
            wr_ptr_r <= wr_ptr_nxt;
            rd_ptr_r <= rd_ptr_nxt;
            count_r <= count_nxt;
            pkt_len_r <= pkt_len_nxt;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_clear_holds: assert property (
        fifo_clear |=> (wr_ptr_r == '0 && rd_ptr_r == '0 && count_r == '0))
        else $error("Endpoint state not zero while FIFO clear is set.");

    chk_count_update: assert property (
        (pkt_done && !fifo_clear) |=> count_r == $past(pkt_sum))
        else $error("Byte count not updated at end of packet.");

    chk_resume_use: assert property (
        $fell(fifo_clear) ##0 byte_wr |=> wr_ptr_r == CNT_W'(1))
        else $error("FIFO not usable after clear was removed.");

    cov_packet: cover property (
        (byte_wr && !fifo_clear) [*3] ##1 pkt_done);

endmodule // ubc_ep_count

// [src/ubc_top.sv]
// Byte count and endpoint FIFO reset registers beside the USB function.
// Assumes the core accesses registers through single-cycle SFR strobes and
// the serial engine reports stored bytes and packet ends on the same clock.
`timescale 1ns/1ps
`include "ubc_cfg.svh"

module ubc_top #(
    parameter int NUM_EP = `UBC_NUM_EP,
    parameter int CNT_W = `UBC_COUNT_W
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_WDATA,
    input wire logic SFR_WR,
    input wire logic SFR_RD,
    output logic [7:0] SFR_RDATA,
    input wire logic [2:0] SELECTED_ENDPOINT_FIELD,
    input wire logic [2:0] RX_EP,
    input wire logic RX_BYTE_WR,
    input wire logic RX_PKT_DONE,
    input wire logic FIFO_RD,
    output logic [NUM_EP-1:0] EP_FIFO_CLEAR,
    output logic [CNT_W-1:0] SEL_WR_PTR,
    output logic [CNT_W-1:0] SEL_RD_PTR
);

    // ======================================================================
    // Address decode
    function automatic ubc_pkg::ubc_reg_sel_t decode(input logic [7:0] a);
        ubc_pkg::ubc_reg_sel_t s;
        s = ubc_pkg::UBC_SEL_NONE;
        if (a == `UBC_ADDR_RX_COUNT_LOW) begin
            s = ubc_pkg::UBC_SEL_LOW;
        end else if (a == `UBC_ADDR_RX_COUNT_HIGH) begin
            s = ubc_pkg::UBC_SEL_HIGH;
        end else if (a == `UBC_ADDR_EP_FIFO_RESET) begin
            s = ubc_pkg::UBC_SEL_RST;
        end
        return s;
    endfunction

    ubc_pkg::ubc_reg_sel_t sel;
    assign sel = decode(SFR_ADDR);

    // ======================================================================
    // Endpoint FIFO reset register
    logic [NUM_EP-1:0] ep_clr_r;
    logic [NUM_EP-1:0] ep_clr_nxt;

    always_comb begin
        ep_clr_nxt = ep_clr_r;
        if (SFR_WR && sel == ubc_pkg::UBC_SEL_RST) begin
            ep_clr_nxt = SFR_WDATA[NUM_EP-1:0];
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ep_clr_r <= `UBC_EP_FIFO_RESET_INIT;
        end else begin
            ep_clr_r <= ep_clr_nxt;
        end
    end

    assign EP_FIFO_CLEAR = ep_clr_r;

    // ======================================================================
    // Per-endpoint pointers and counts
    logic [CNT_W-1:0] ep_wr_ptr [NUM_EP];
    logic [CNT_W-1:0] ep_rd_ptr [NUM_EP];
    logic [CNT_W-1:0] ep_count [NUM_EP];

    for (genvar n = 0; n < NUM_EP; n++) begin : g_ep
        ubc_ep_count #(
            .CNT_W(CNT_W)
        ) u_ep (
            .clk(CLK_SYS),
            .rst(SYS_RST),
            .fifo_clear(ep_clr_r[n]),
            .byte_wr(RX_BYTE_WR && RX_EP == 3'(n)),
            .byte_rd(FIFO_RD && SELECTED_ENDPOINT_FIELD == 3'(n)),
            .pkt_done(RX_PKT_DONE && RX_EP == 3'(n)),
            .wr_ptr_r(ep_wr_ptr[n]),
            .rd_ptr_r(ep_rd_ptr[n]),
            .count_r(ep_count[n])
        );
    end

    // ======================================================================
    // Selected endpoint view
    logic sel_valid;
    logic [CNT_W-1:0] sel_count;
    logic [CNT_W-1:0] sel_wr;
    logic [CNT_W-1:0] sel_rd;

    always_comb begin
        sel_valid = 32'(SELECTED_ENDPOINT_FIELD) < NUM_EP;
        sel_count = '0;
        sel_wr = '0;
        sel_rd = '0;
        if (sel_valid) begin
            sel_count = ep_count[SELECTED_ENDPOINT_FIELD];
            sel_wr = ep_wr_ptr[SELECTED_ENDPOINT_FIELD];
            sel_rd = ep_rd_ptr[SELECTED_ENDPOINT_FIELD];
        end
    end

    // ======================================================================
    // Read data
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic [CNT_W-1:0] sel_wr_r;
    logic [CNT_W-1:0] sel_rd_r;

    always_comb begin
        rdata_nxt = rdata_r;
        if (SFR_RD) begin
            unique case (sel)
                ubc_pkg::UBC_SEL_LOW: begin
                    rdata_nxt = sel_count[`UBC_LOW_MSB:0];
                end
                ubc_pkg::UBC_SEL_HIGH: begin
                    rdata_nxt = {5'h00,
                        sel_count[`UBC_HIGH_LSB +: `UBC_HIGH_W]};
                end
                ubc_pkg::UBC_SEL_RST: begin
                    rdata_nxt = {1'h0, ep_clr_r};
                end
                ubc_pkg::UBC_SEL_NONE: begin
                    rdata_nxt = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            rdata_r <= `UBC_RDATA_INIT;
            sel_wr_r <= '0;
            sel_rd_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            sel_wr_r <= sel_wr;
            sel_rd_r <= sel_rd;
        end
    end

    assign SFR_RDATA = rdata_r;
    assign SEL_WR_PTR = sel_wr_r;
    assign SEL_RD_PTR = sel_rd_r;

    // ======================================================================
    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);

    chk_low_count: assert property (
        (SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_LOW && sel_valid)
        |=> SFR_RDATA == $past(sel_count[7:0]))
        else $error("Low count read returned wrong value.");

    chk_high_count: assert property (
        (SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_HIGH && sel_valid)
        |=> SFR_RDATA[2:0] == $past(sel_count[10:8]))
        else $error("High count read returned wrong value.");

    chk_high_reserved: assert property (
        (SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_HIGH)
        |=> SFR_RDATA[7:3] == 5'h00)
        else $error("Reserved high count bits read as one.");

    chk_select_ep: assert property (
        (SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_LOW
        && SELECTED_ENDPOINT_FIELD == 3'h6)
        |=> SFR_RDATA == $past(ep_count[6][7:0]))
        else $error("Count read not taken from selected endpoint.");

    chk_reset_write: assert property (
        (SFR_WR && SFR_ADDR == `UBC_ADDR_EP_FIFO_RESET)
        |=> EP_FIFO_CLEAR == $past(SFR_WDATA[6:0]))
        else $error("Endpoint reset bits not stored.");

    chk_reset_read: assert property (
        (SFR_RD && SFR_ADDR == `UBC_ADDR_EP_FIFO_RESET)
        |=> SFR_RDATA[7] == 1'h0 && SFR_RDATA[6:0] == $past(EP_FIFO_CLEAR))
        else $error("Endpoint reset read returned wrong value.");

    chk_clear_zero: assert property (
        (EP_FIFO_CLEAR[0] && SELECTED_ENDPOINT_FIELD == 3'h0) [*2]
        |=> SEL_WR_PTR == '0 && SEL_RD_PTR == '0)
        else $error("Cleared endpoint pointers not zero.");

    // Reference length of the packet being stored into endpoint 1.
    logic [CNT_W-1:0] ep1_len_r;
    logic [CNT_W-1:0] ep1_len_nxt;
    logic ep1_byte;

    assign ep1_byte = RX_BYTE_WR && RX_EP == 3'h1;

    always_comb begin
        ep1_len_nxt = ep1_len_r;
        if (ep_clr_r[1] || (RX_PKT_DONE && RX_EP == 3'h1)) begin
            ep1_len_nxt = '0;
        end else if (ep1_byte) begin
            ep1_len_nxt = ep1_len_r + CNT_W'(1);
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            ep1_len_r <= '0;
        end else begin
            ep1_len_r <= ep1_len_nxt;
        end
    end

    chk_packet_count: assert property (
        (RX_PKT_DONE && RX_EP == 3'h1 && !EP_FIFO_CLEAR[1])
        |=> ep_count[1] == $past(ep1_len_r + CNT_W'(ep1_byte)))
        else $error("Packet count update failed.");

    cov_clear_cycle: cover property (
        $rose(EP_FIFO_CLEAR[0]) ##[1:20] $fell(EP_FIFO_CLEAR[0]));

    cov_read_low: cover property (
        SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_LOW && sel_count != '0);

    cov_read_high: cover property (
        SFR_RD && SFR_ADDR == `UBC_ADDR_RX_COUNT_HIGH && sel_count[8]);

endmodule // ubc_top

// [sim/ubc_rx_model.sv]
// Stand-in for the receive engine that stores packets into endpoint FIFOs.
// Assumes a single caller of send_pkt at a time, on the system clock.
`timescale 1ns/1ps

module ubc_rx_model (
    input wire logic clk,
    output logic [2:0] ep,
    output logic byte_wr,
    output logic pkt_done
);
    initial begin
        ep = 3'h0;
        byte_wr = 1'b0;
        pkt_done = 1'b0;
    end

    // ==================================================================
    // Packet sender
    // Sends len bytes, then one end pulse; a set slow idles between bytes.
    // The endpoint lines show the inverse value while nothing is sent.
    task automatic send_pkt(input logic [2:0] e, input int len,
                            input bit slow);
        for (int i = 0; i < len; i++) begin
            @(posedge clk);
            ep <= e;
            byte_wr <= 1'b1;
            if (slow) begin
                @(posedge clk);
                byte_wr <= 1'b0;
                ep <= ~e;
            end
        end
        @(posedge clk);
        byte_wr <= 1'b0;
        pkt_done <= 1'b1;
        ep <= e;
        @(posedge clk);
        pkt_done <= 1'b0;
        ep <= ~e;
    endtask
endmodule // ubc_rx_model

// [sim/tb_usb_ep_bytecount_fifo_reset.sv]
// Bench for the byte count and endpoint FIFO reset registers.
// Assumes ubc_cfg.svh on the include path and ubc_rx_model compiled.
`timescale 1ns/1ps
`include "ubc_cfg.svh"

module tb_usb_ep_bytecount_fifo_reset;
    localparam bit [7:0] A_RST = `UBC_ADDR_EP_FIFO_RESET;
    localparam bit [7:0] A_LO = `UBC_ADDR_RX_COUNT_LOW;
    localparam bit [7:0] A_HI = `UBC_ADDR_RX_COUNT_HIGH;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic [2:0] sel = 3'h0;
    logic [2:0] rx_ep;
    logic byte_wr;
    logic pkt_done;
    logic fifo_rd = 1'b0;
    logic [6:0] clr;
    logic [10:0] wptr;
    logic [10:0] rptr;
    int fail_count = 0;
    int check_count = 0;

    always #20 clk = ~clk;

    ubc_top i_dut (
        .CLK_SYS(clk),
        .SYS_RST(rst),
        .SFR_ADDR(addr),
        .SFR_WDATA(wdata),
        .SFR_WR(wr),
        .SFR_RD(rd),
        .SFR_RDATA(rdata),
        .SELECTED_ENDPOINT_FIELD(sel),
        .RX_EP(rx_ep),
        .RX_BYTE_WR(byte_wr),
        .RX_PKT_DONE(pkt_done),
        .FIFO_RD(fifo_rd),
        .EP_FIFO_CLEAR(clr),
        .SEL_WR_PTR(wptr),
        .SEL_RD_PTR(rptr)
    );

    ubc_rx_model i_rx (
        .clk(clk),
        .ep(rx_ep),
        .byte_wr(byte_wr),
        .pkt_done(pkt_done)
    );

    // ==================================================================
    // Compare, access and closing tasks
    task automatic check(input string nm, input logic [10:0] seen,
                         input logic [10:0] exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check($sformatf("reg %h", a), {3'h0, rdata}, {3'h0, exp});
    endtask

    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ==================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        sfr_rd(A_RST, 8'h00);
        sfr_rd(A_LO, 8'h00);
        sfr_rd(A_HI, 8'h00);
        sfr_rd(8'h10, 8'h00);
        // Firmware clears all endpoint FIFOs after the hardware reset.
        sfr_wr(A_RST, 8'h7F);
        sfr_rd(A_RST, 8'h7F);
        check("clear bits", {4'h0, clr}, 11'h07F);
        i_rx.send_pkt(3'h1, 3, 1'b0);
        sel <= 3'h1;
        sfr_rd(A_LO, 8'h00);
        check("wr ptr", wptr, 11'h000);
        // The first byte lands in the cycle in which the clear bit falls.
        fork
            sfr_wr(A_RST, 8'h00);
            begin
                @(posedge clk);
                i_rx.send_pkt(3'h1, 2, 1'b1);
            end
        join
        sfr_rd(A_LO, 8'h02);
        sfr_rd(A_HI, 8'h00);
        i_rx.send_pkt(3'h6, 300, 1'b0);
        sfr_rd(A_LO, 8'h02);
        @(posedge clk);
        sel <= 3'h6;
        sfr_rd(A_LO, 8'h2C);
        sfr_rd(A_HI, 8'h01);
        // Two firmware reads move the endpoint 6 read pointer.
        @(posedge clk);
        fifo_rd <= 1'b1;
        repeat (2) @(posedge clk);
        fifo_rd <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("rd ptr", rptr, 11'h002);
        check("wr ptr", wptr, 11'h12C);
        // Clearing endpoint 6 zeroes its pointers and count.
        sfr_wr(A_RST, 8'h40);
        sfr_rd(A_LO, 8'h00);
        check("rd ptr", rptr, 11'h000);
        check("clear bits", {4'h0, clr}, 11'h040);
        tally_and_finish();
    end

    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        tally_and_finish();
    end
endmodule // tb_usb_ep_bytecount_fifo_reset
